/* File: logic/otfs_top.sv */
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "otfs_defs.svh"

// Behaviour
// - Two relays, one collector output, one fast output, each with own code.
// - Same code may drive several outputs, each following independently.
// - Code 0 leaves the output inactive.
// - Code 1: on while running with frequency output.
// - Code 2 forward running, code 3 reverse running, both with frequency.
// - Code 4: on while jogging with frequency output.
// - Code 5: on while the drive is faulted.
// - Code 9: on when output and commanded frequency both zero.
// - Code 10: on when running at upper limit frequency.
// - Code 11: on when running at lower limit frequency.
// - Code 12: on when circuits established and no protection active.
// - Code 13: on while pre-exciting.
// - Code 14 overload pre-alarm, code 15 underload pre-alarm.
// - Code 16 sequencer stage done, code 17 sequencer cycle done.
// - Codes 23 to 25 follow Modbus, fieldbus, Ethernet virtual values.
// - Code 26: on once bus voltage is established.
// - Codes 30 to 32: positioning, spindle return, spindle scaling done.
// - Code 33: on while speed sits at a limit.
// - Code 34: on while bus voltage below low threshold.
// - Code 35: on when underload-stop enabled and underload present.
// - Code 36: on once switched from speed to position mode.
// - Fast output mode 0 pulses, 1 switches; defaults to 0.

module otfs_top #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire otfs_pkg::otfs_status_t drive_status,
  input wire logic [15:0] bus_voltage,
  input wire logic pulse_train,
  output logic relay_one_drive,
  output logic relay_two_drive,
  output logic collector_output_one,
  output logic fast_pulse_output
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  generate
    if (ADDR_W < 6 || ADDR_W > 8) begin : g_bad_addr
      $error("otfs_top: ADDR_W must be 6 to 8");
    end
    if ($bits(otfs_pkg::otfs_status_t) > `OTFS_STATUS_OUT_LSB) begin : g_bad_status
      $error("otfs_top: status sources overlap the output field");
    end
    if (`OTFS_VIRT_W > 4) begin : g_bad_virt
      $error("otfs_top: virtual value field exceeds its nibble");
    end
    if (`OTFS_FAST_MODE_BIT > 15) begin : g_bad_mode
      $error("otfs_top: fast mode bit outside its register");
    end
  endgenerate

  // ----------------------------------------
  // State
  // ----------------------------------------
  otfs_pkg::otfs_state_t cur_ff;
  otfs_pkg::otfs_state_t nxt_cur;
  logic [3:0] sel_on;
  logic low_bus;
  logic aw_now;
  logic w_now;
  logic have_aw;
  logic have_w;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [7:0] rd_addr;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;
  logic wr_fire;
  logic wr_fast_mode;
  logic [3:0] wr_fn;
  logic wr_virt;
  logic wr_uls;
  logic wr_thr;
  logic [3:0] drv_nxt;
  logic [31:0] status_word;

  // Outputs index: 0 relay one, 1 relay two, 2 collector, 3 fast
  localparam int IDX_FAST = 3;

  // ----------------------------------------
  // Byte-lane merge
  // ----------------------------------------
  // Only the two low lanes exist; upper strobes are ignored
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // ----------------------------------------
  // Per-output selectors
  // ----------------------------------------
  // Each output has its own decoder, so a shared code never couples them
  generate
    for (genvar gi = 0; gi < 4; gi++) begin : g_sel
      otfs_select u_sel (
        .code(cur_ff.fn_code[gi]),
        .st(cur_ff.st_sync),
        .virt(cur_ff.virt[gi*4 +: `OTFS_VIRT_W]),
        .low_bus(low_bus),
        .uls_en(cur_ff.uls_en[0]),
        .on(sel_on[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Low bus voltage
  // ----------------------------------------
  // Bus voltage comes from same-clock measurement logic
  assign low_bus = bus_voltage < cur_ff.low_thr;

  // ----------------------------------------
  // Terminal drive
  // ----------------------------------------
  // Pulse mode hands the fast pin to the pulse generator
  generate
    for (genvar go = 0; go < 4; go++) begin : g_drv
      if (go == IDX_FAST) begin : g_fast
        assign drv_nxt[go] = cur_ff.fast_mode[`OTFS_FAST_MODE_BIT] ? sel_on[go] : pulse_train;
      end else begin : g_plain
        assign drv_nxt[go] = sel_on[go];
      end
    end
  endgenerate

  // ----------------------------------------
  // Bus handshakes
  // ----------------------------------------
  // One write in flight; a pending response blocks new address and data
  assign s_axi_awready = ~cur_ff.aw_got & ~cur_ff.bvalid;
  assign s_axi_wready = ~cur_ff.w_got & ~cur_ff.bvalid;
  assign s_axi_arready = ~cur_ff.rvalid;
  assign s_axi_bvalid = cur_ff.bvalid;
  assign s_axi_bresp = cur_ff.bresp;
  assign s_axi_rvalid = cur_ff.rvalid;
  assign s_axi_rdata = cur_ff.rdata;
  assign s_axi_rresp = cur_ff.rresp;

  assign aw_now = s_axi_awvalid & s_axi_awready;
  assign w_now = s_axi_wvalid & s_axi_wready;
  assign have_aw = cur_ff.aw_got | aw_now;
  assign have_w = cur_ff.w_got | w_now;
  assign wr_addr = aw_now ? 8'(s_axi_awaddr) : cur_ff.awaddr;
  assign wr_data = w_now ? s_axi_wdata : cur_ff.wdata;
  assign wr_strb = w_now ? s_axi_wstrb : cur_ff.wstrb;
  assign rd_addr = 8'(s_axi_araddr);

  // ----------------------------------------
  // Pin outputs
  // ----------------------------------------
  assign relay_one_drive = cur_ff.outs[0];
  assign relay_two_drive = cur_ff.outs[1];
  assign collector_output_one = cur_ff.outs[2];
  assign fast_pulse_output = cur_ff.outs[IDX_FAST];

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  // Synchronised sources low, registered terminal levels above them
  always_comb begin
    status_word = 32'h00000000;
    status_word[$bits(otfs_pkg::otfs_status_t)-1:0] = cur_ff.st_sync;
    status_word[`OTFS_STATUS_OUT_LSB +: 4] = cur_ff.outs;
  end

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h00000000;
    case (rd_addr)
      `OTFS_FAST_MODE_OFS: rd_word[15:0] = cur_ff.fast_mode;
      `OTFS_COLL_FN_OFS: rd_word[15:0] = cur_ff.fn_code[2];
      `OTFS_RELAY1_FN_OFS: rd_word[15:0] = cur_ff.fn_code[0];
      `OTFS_RELAY2_FN_OFS: rd_word[15:0] = cur_ff.fn_code[1];
      `OTFS_FAST_FN_OFS: rd_word[15:0] = cur_ff.fn_code[IDX_FAST];
      `OTFS_VIRT_OFS: rd_word[15:0] = cur_ff.virt;
      `OTFS_ULS_EN_OFS: rd_word[15:0] = cur_ff.uls_en;
      `OTFS_LOW_THR_OFS: rd_word[15:0] = cur_ff.low_thr;
      `OTFS_STATUS_OFS: rd_word = status_word;
      default: rd_hit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  // One strobe per register keeps the update logic free of address compares
  always_comb begin
    wr_fire = have_aw & have_w;
    wr_hit = 1'b1;
    wr_fast_mode = 1'b0;
    wr_fn = 4'h0;
    wr_virt = 1'b0;
    wr_uls = 1'b0;
    wr_thr = 1'b0;
    case (wr_addr)
      `OTFS_FAST_MODE_OFS: begin
        wr_fast_mode = wr_fire;
      end
      `OTFS_COLL_FN_OFS: begin
        wr_fn[2] = wr_fire;
      end
      `OTFS_RELAY1_FN_OFS: begin
        wr_fn[0] = wr_fire;
      end
      `OTFS_RELAY2_FN_OFS: begin
        wr_fn[1] = wr_fire;
      end
      `OTFS_FAST_FN_OFS: begin
        wr_fn[IDX_FAST] = wr_fire;
      end
      `OTFS_VIRT_OFS: begin
        wr_virt = wr_fire;
      end
      `OTFS_ULS_EN_OFS: begin
        wr_uls = wr_fire;
      end
      `OTFS_LOW_THR_OFS: begin
        wr_thr = wr_fire;
      end
      // Status is read-only; writing it is refused
      default: begin
        wr_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_cur = cur_ff;
    // Status pins come from another domain: two stages first
    nxt_cur.st_meta = drive_status;
    nxt_cur.st_sync = cur_ff.st_meta;

    // Write address and data, in either order
    if (aw_now) begin
      nxt_cur.aw_got = 1'b1;
      nxt_cur.awaddr = 8'(s_axi_awaddr);
    end
    if (w_now) begin
      nxt_cur.w_got = 1'b1;
      nxt_cur.wdata = s_axi_wdata;
      nxt_cur.wstrb = s_axi_wstrb;
    end
    if (wr_fire) begin
      nxt_cur.aw_got = 1'b0;
      nxt_cur.w_got = 1'b0;
      nxt_cur.bvalid = 1'b1;
      nxt_cur.bresp = wr_hit ? `OTFS_RESP_OKAY : `OTFS_RESP_SLVERR;
    end
    if (wr_fast_mode) begin
      nxt_cur.fast_mode = merge16(cur_ff.fast_mode, wr_data, wr_strb);
    end
    for (int i = 0; i < 4; i++) begin
      if (wr_fn[i]) begin
        nxt_cur.fn_code[i] = merge16(cur_ff.fn_code[i], wr_data, wr_strb);
      end
    end
    if (wr_virt) begin
      nxt_cur.virt = merge16(cur_ff.virt, wr_data, wr_strb);
    end
    if (wr_uls) begin
      nxt_cur.uls_en = merge16(cur_ff.uls_en, wr_data, wr_strb);
    end
    if (wr_thr) begin
      nxt_cur.low_thr = merge16(cur_ff.low_thr, wr_data, wr_strb);
    end
    if (cur_ff.bvalid && s_axi_bready) begin
      nxt_cur.bvalid = 1'b0;
    end

    // Read channel
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_cur.rvalid = 1'b1;
      nxt_cur.rdata = rd_word;
      nxt_cur.rresp = rd_hit ? `OTFS_RESP_OKAY : `OTFS_RESP_SLVERR;
    end else if (cur_ff.rvalid && s_axi_rready) begin
      nxt_cur.rvalid = 1'b0;
    end

    // Terminal drive
    nxt_cur.outs = drv_nxt;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_ff <= '0;
      cur_ff.fast_mode <= `OTFS_FAST_MODE_RST;
      cur_ff.fn_code[0] <= `OTFS_RELAY1_FN_RST;
      cur_ff.fn_code[1] <= `OTFS_RELAY2_FN_RST;
      cur_ff.fn_code[2] <= `OTFS_COLL_FN_RST;
      cur_ff.fn_code[IDX_FAST] <= `OTFS_FAST_FN_RST;
      cur_ff.low_thr <= `OTFS_LOW_THR_RST;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

endmodule

/* File: logic/otfs_defs.svh */
`ifndef OTFS_DEFS_SVH
`define OTFS_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OTFS_FAST_MODE_OFS 8'h00
`define OTFS_COLL_FN_OFS 8'h04
`define OTFS_RELAY1_FN_OFS 8'h08
`define OTFS_RELAY2_FN_OFS 8'h0C
`define OTFS_FAST_FN_OFS 8'h10
`define OTFS_VIRT_OFS 8'h14
`define OTFS_ULS_EN_OFS 8'h18
`define OTFS_LOW_THR_OFS 8'h1C
`define OTFS_STATUS_OFS 8'h20

// ----------------------------------------
// Reset values
// ----------------------------------------
`define OTFS_FAST_MODE_RST 16'h0000
`define OTFS_COLL_FN_RST 16'h0000
`define OTFS_RELAY1_FN_RST 16'h0001
`define OTFS_RELAY2_FN_RST 16'h0005
`define OTFS_FAST_FN_RST 16'h0000
`define OTFS_LOW_THR_RST 16'h0000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define OTFS_FAST_MODE_BIT 0
`define OTFS_VIRT_W 3
`define OTFS_STATUS_OUT_LSB 24

// ----------------------------------------
// AXI responses
// ----------------------------------------
`define OTFS_RESP_OKAY 2'h0
`define OTFS_RESP_SLVERR 2'h2

`endif

/* File: logic/otfs_pkg.sv */
`include "otfs_defs.svh"

package otfs_pkg;

  // ----------------------------------------
  // Drive status sources
  // ----------------------------------------
  typedef struct packed {
    logic running;
    logic forward;
    logic jogging;
    logic freq_out;
    logic fault;
    logic out_freq_zero;
    logic cmd_freq_zero;
    logic at_upper;
    logic at_lower;
    logic mains_ok;
    logic ctrl_ok;
    logic protect_active;
    logic pre_exciting;
    logic overload_pre;
    logic underload_pre;
    logic plc_stage_done;
    logic plc_cycle_done;
    logic bus_established;
    logic position_done;
    logic spindle_return_done;
    logic spindle_scale_done;
    logic speed_limit;
    logic underload_state;
    logic pos_mode_switched;
  } otfs_status_t;

  // ----------------------------------------
  // Whole state of the top module
  // ----------------------------------------
  typedef struct packed {
    otfs_status_t st_meta;
    otfs_status_t st_sync;
    logic [15:0] fast_mode;
    logic [3:0][15:0] fn_code;
    logic [15:0] virt;
    logic [15:0] uls_en;
    logic [15:0] low_thr;
    logic [3:0] outs;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } otfs_state_t;

endpackage

/* File: logic/otfs_select.sv */
`timescale 1ns/100ps
`include "otfs_defs.svh"

module otfs_select (
  input wire logic [15:0] code,
  input wire otfs_pkg::otfs_status_t st,
  input wire logic [`OTFS_VIRT_W-1:0] virt,
  input wire logic low_bus,
  input wire logic uls_en,
  output logic on
);

  logic run_f;

  // ----------------------------------------
  // Function code decode
  // ----------------------------------------
  always_comb begin
    run_f = st.running & st.freq_out;
    case (code)
      16'h0001: on = run_f;
      16'h0002: on = run_f & st.forward;
      16'h0003: on = run_f & ~st.forward;
      16'h0004: on = run_f & st.jogging;
      16'h0005: on = st.fault;
      16'h0009: on = st.out_freq_zero & st.cmd_freq_zero;
      16'h000A: on = st.at_upper;
      16'h000B: on = st.at_lower;
      16'h000C: on = st.mains_ok & st.ctrl_ok & ~st.protect_active;
      16'h000D: on = st.pre_exciting;
      16'h000E: on = st.overload_pre;
      16'h000F: on = st.underload_pre;
      16'h0010: on = st.plc_stage_done;
      16'h0011: on = st.plc_cycle_done;
      16'h0017: on = virt[0];
      16'h0018: on = virt[1];
      16'h0019: on = virt[2];
      16'h001A: on = st.bus_established;
      16'h001E: on = st.position_done;
      16'h001F: on = st.spindle_return_done;
      16'h0020: on = st.spindle_scale_done;
      16'h0021: on = st.speed_limit;
      16'h0022: on = low_bus;
      16'h0023: on = uls_en & st.underload_state;
      16'h0024: on = st.pos_mode_switched;
      // Frequency detect codes 6 to 8 need thresholds held elsewhere
      default: on = 1'b0;
    endcase
  end

endmodule

/* File: verification/otfs_load.sv */
`timescale 1ns/100ps
// Loads: coil closes while driven; collector lines pulled up, low when on
module otfs_load (
  input wire logic [3:0] drv,
  output logic [3:0] closed,
  output logic [1:0] line_n
);
  assign closed = drv;
  assign line_n = ~drv[1:0];
endmodule

/* File: verification/otfs_chk_asserts.sv */
`timescale 1ns/100ps
`include "otfs_defs.svh"
module otfs_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire otfs_pkg::otfs_status_t drive_status,
  input wire logic [15:0] bus_voltage,
  input wire logic pulse_train,
  input wire logic relay_one_drive,
  input wire logic relay_two_drive,
  input wire logic collector_output_one,
  input wire logic fast_pulse_output
);
  logic [3:0] outs;
  assign outs = {relay_one_drive, relay_two_drive, collector_output_one, fast_pulse_output};
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ------
  // Sequences
  // ------
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // No cause for any output to move
  sequence quiet;
    $stable(drive_status) && $stable(bus_voltage) && $stable(pulse_train) && !s_axi_awvalid && !s_axi_bvalid;
  endsequence
  // ------
  // Checks
  // ------
  a_b_answer: assert property (wr_taken |=> s_axi_bvalid) else $error("write not answered");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_w_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  a_rd_upper: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr != `OTFS_STATUS_OFS
    |=> s_axi_rdata[31:16] == 16'h0000) else $error("upper bits set");
  a_status_outs: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `OTFS_STATUS_OFS
    |=> s_axi_rdata[31:28] == 4'h0
    && s_axi_rdata[27:24] == $past({fast_pulse_output, collector_output_one, relay_two_drive, relay_one_drive}))
    else $error("status output field wrong");
  a_outs_quiet: assert property (quiet [*4] |=> $stable(outs)) else $error("output moved without cause");
  a_reset_idle: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && outs == 4'h0) else $error("not idle after reset");
endmodule
bind otfs_top otfs_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid,
  .s_axi_rready, .drive_status, .bus_voltage, .pulse_train, .relay_one_drive, .relay_two_drive,
  .collector_output_one, .fast_pulse_output);

/* File: verification/output_terminal_function_select_tb_top.sv */
`timescale 1ns/100ps
module output_terminal_function_select_tb_top;
  logic aclk, aresetn, pulse_train;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb, outs, closed;
  logic [1:0] s_axi_bresp, s_axi_rresp, line_n;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic relay_one_drive, relay_two_drive, collector_output_one, fast_pulse_output;
  otfs_pkg::otfs_status_t drive_status;
  logic [15:0] bus_voltage;
  int bad_count = 0;
  int n_tests = 0;
  localparam logic [5:0] CODE [21] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D,
    6'h0E, 6'h0F, 6'h10, 6'h11, 6'h1A, 6'h1E, 6'h1F, 6'h20, 6'h21, 6'h23, 6'h24};
  localparam logic [23:0] ONP [21] = '{24'h900000, 24'hD00000, 24'h900000, 24'hB00000, 24'h080000,
    24'h060000, 24'h010000, 24'h008000, 24'h006000, 24'h000800, 24'h000400, 24'h000200, 24'h000100,
    24'h000080, 24'h000040, 24'h000020, 24'h000010, 24'h000008, 24'h000004, 24'h000002, 24'h000001};
  localparam logic [23:0] OFFP [21] = '{24'h800000, 24'h900000, 24'hD00000, 24'h900000, 24'h0, 24'h040000,
    24'h0, 24'h0, 24'h007000, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0};
  assign outs = {relay_one_drive, relay_two_drive, collector_output_one, fast_pulse_output};
  otfs_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .drive_status, .bus_voltage, .pulse_train, .relay_one_drive, .relay_two_drive, .collector_output_one,
    .fast_pulse_output);
  otfs_load u_load (.drv(outs), .closed, .line_n);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ------
  // Shared tasks
  // ------
  task automatic cw(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: word %h, expected %h", $time, g, e);
    end
  endtask
  task automatic cb(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: output %b, expected %b", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r = 2'h0, input int lag = 0);
    int t;
    logic ga, gw;
    t = 0;
    ga = 1'b0;
    gw = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    while (!(ga && gw) && t < 50) begin
      t++;
      @(posedge aclk);
      ga |= s_axi_awready;
      gw |= s_axi_wready;
      s_axi_awvalid <= !ga;
      s_axi_wvalid <= !gw;
    end
    do begin
      @(posedge aclk);
      t++;
    end while (!s_axi_bvalid && t < 50);
    // Late bready makes the response wait, which it must do unchanged
    if (lag > 0) begin
      repeat (lag) @(posedge aclk);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
    end
    s_axi_bready <= 1'b0;
    cw({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h1, r});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0, input int lag = 0);
    int t;
    t = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    do begin
      @(posedge aclk);
      t++;
    end while (!s_axi_arready && t < 50);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      t++;
    end while (!s_axi_rvalid && t < 50);
    if (lag > 0) begin
      repeat (lag) @(posedge aclk);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
    end
    s_axi_rready <= 1'b0;
    cw({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h1, r});
    cw(s_axi_rdata, d);
  endtask
  // Sync stages and output flop need three edges; five leaves margin
  task automatic drv(input logic [23:0] s, input logic [15:0] v = 16'h0000);
    @(posedge aclk);
    drive_status <= s;
    bus_voltage <= v;
    repeat (5) @(posedge aclk);
  endtask
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_regs();
    logic [2:0] rv [8] = '{3'h0, 3'h0, 3'h1, 3'h5, 3'h0, 3'h0, 3'h0, 3'h0};
    for (int i = 0; i < 8; i++) begin
      rd(8'(4 * i), {29'h0, rv[i]});
    end
    rd(8'h24, 32'h0, 2'h2, 3);
    wr(8'h24, 16'h1234, 2'h2, 3);
    wr(8'h20, 16'h0001, 2'h2);
  endtask
  task automatic t_codes();
    wr(8'h18, 16'h0001);
    for (int i = 0; i < 21; i++) begin
      wr(8'h08, {10'h000, CODE[i]});
      drv(ONP[i]);
      cb(relay_one_drive, 1'b1);
      drv(OFFP[i]);
      cb(relay_one_drive, 1'b0);
    end
    rd(8'h08, 32'h00000024);
    wr(8'h18, 16'h0000);
    wr(8'h08, 16'h0023);
    drv(24'h000002);
    cb(relay_one_drive, 1'b0);
  endtask
  task automatic t_virt();
    logic [15:0] rsv [9] = '{16'h0000, 16'h0006, 16'h0008, 16'h0012, 16'h0016, 16'h001B, 16'h001D, 16'h0025, 16'hFFFF};
    for (int n = 0; n < 3; n++) begin
      wr(8'h14, 16'(1 << n));
      wr(8'h08, 16'(23 + n));
      drv(24'h0);
      cb(relay_one_drive, 1'b1);
      wr(8'h14, 16'(7 ^ (1 << n)));
      drv(24'h0);
      cb(relay_one_drive, 1'b0);
    end
    wr(8'h14, 16'h7777);
    wr(8'h18, 16'h0001);
    for (int k = 0; k < 9; k++) begin
      wr(8'h08, rsv[k]);
      drv(24'hFFFFFF);
      cb(relay_one_drive, 1'b0);
    end
  endtask
  task automatic t_low_bus();
    wr(8'h1C, 16'h0100);
    rd(8'h1C, 32'h00000100);
    wr(8'h08, 16'h0022);
    drv(24'h0, 16'h00FF);
    cb(relay_one_drive, 1'b1);
    drv(24'h0, 16'h0100);
    cb(relay_one_drive, 1'b0);
  endtask
  task automatic t_multi();
    wr(8'h00, 16'h0001);
    wr(8'h04, 16'h0005);
    wr(8'h08, 16'h0005);
    wr(8'h10, 16'h0005);
    drv(24'h080000);
    cw({28'h0, outs}, 32'h0000000F);
    cw({28'h0, closed}, 32'h0000000F);
    cw({30'h0, line_n}, 32'h00000000);
    rd(8'h20, 32'h0F080000);
    wr(8'h08, 16'h0001);
    drv(24'h900000);
    cw({28'h0, outs}, 32'h00000008);
    cw({30'h0, line_n}, 32'h00000003);
  endtask
  task automatic t_pulse();
    wr(8'h00, 16'h0000);
    pulse_train <= 1'b1;
    repeat (2) @(posedge aclk);
    cb(fast_pulse_output, 1'b1);
    pulse_train <= 1'b0;
    repeat (2) @(posedge aclk);
    cb(fast_pulse_output, 1'b0);
    wr(8'h00, 16'h0001);
    wr(8'h10, 16'h0000);
    pulse_train <= 1'b1;
    drv(24'h080000);
    cb(fast_pulse_output, 1'b0);
  endtask
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, pulse_train} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
    s_axi_wstrb = 4'hF;
    drive_status = '0;
    bus_voltage = 16'h0000;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_codes();
    t_virt();
    t_low_bus();
    t_multi();
    t_pulse();
    test_done();
  end
  initial begin
    repeat (30000) @(posedge aclk);
    bad_count++;
    test_done();
  end
endmodule
